/* File: rtl/rdp_consts.svh */
// constants of the decoder target port: addresses, byte counts, timing and reset values
`ifndef RDP_CONSTS_SVH
`define RDP_CONSTS_SVH

// fixed upper six bits of the target address
`define RDP_ADDR_HI      6'h08
// write bytes per transfer, index of the last read byte
`define RDP_WR_BYTES     2'h3
`define RDP_RD_LAST      3'h6
// crystal clock rate in MHz
`define RDP_MCLK_MHZ     20
// quality measurement time (longest) and block ready low time, in microseconds
`define RDP_MEAS_TIME_US 850
`define RDP_MEAS_CYC     (`RDP_MEAS_TIME_US * `RDP_MCLK_MHZ)
`define RDP_READY_TIME_US 10100
`define RDP_READY_CYC    (`RDP_READY_TIME_US * `RDP_MCLK_MHZ)
// sensitivity field: position in control word, 0 dB code, bit position of the quality step
`define RDP_SENS_POS     16
`define RDP_SENS_0DB     5'h0F
`define RDP_QSTEP_POS    4
// control word reset value: sensitivity at 0 dB, other bytes clear
`define RDP_CTRL_RST     24'h0F0000
// host: master clock cycles per quarter of the bus clock period
`define RDP_SCL_QTR_CYC  50

`endif

/* File: rtl/rdp_pkg.sv */
// types shared by both ends of the decoder target port
package rdp_pkg;

  typedef enum logic [1:0] {
    LNK_IDLE  = 2'b00,
    LNK_ADDR  = 2'b01,
    LNK_WRITE = 2'b10,
    LNK_READ  = 2'b11
  } rdp_link_state_type;

  typedef enum logic [1:0] {
    HST_IDLE  = 2'b00,
    HST_START = 2'b01,
    HST_BIT   = 2'b10,
    HST_STOP  = 2'b11
  } rdp_host_state_type;

endpackage : rdp_pkg

/* File: rtl/rdp_i2c_if.sv */
// two-wire link between bus master and decoder target port
`timescale 1ns/1ps
interface rdp_i2c_if;
  logic scl;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sda;

  // open-drain wire with pull-up: low when any enabled driver drives low
  assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

  modport host (output scl, output hostSdaOut, output hostSdaOe, input sda);
  modport dev  (input scl, input sda, output devSdaOut, output devSdaOe);
endinterface : rdp_i2c_if

/* File: rtl/rdp_target_port.sv */
// decoder end: target address, byte sequencing, acknowledges, data ready and quality measurement
`timescale 1ns/1ps
`include "rdp_consts.svh"

// Summary of operation
// - master opens with START, address, direction
// - upper six address bits fixed 001000
// - address low bit follows strap pin
// - every byte shifted most significant first
// - receiver acknowledges each byte, ninth clock
// - master ends every transfer with STOP
// - early STOP ends transfer cleanly
// - write error: no acknowledge, master stops
// - write bytes taken as zero, one, two
// - read bytes returned zero through six
// - master acknowledges six, then not-acknowledge
// - quality measured within 850 us after acknowledge
// - quality reported as four-bit step code
// - five-bit sensitivity, 01111 means 0 dB
// - ready low on new block, high later
module rdp_target_port
  import rdp_pkg::*;
#(
  parameter int MEAS_CYC  = `RDP_MEAS_CYC,
  parameter int READY_CYC = `RDP_READY_CYC
)
(
  // crystal clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // two-wire link, clocked by the master's bus clock
  rdp_i2c_if.dev           link,
  // address select strap
  input  wire logic        addrSelectStrap,
  // block data from the decoder core
  input  wire logic        newBlockValid,
  input  wire logic [55:0] newBlockData,
  // level from the quality detector front end
  input  wire logic [7:0]  rfLevel,
  // results
  output logic             blockReadyN,
  output logic [23:0]      ctrlWord,
  output logic             ctrlStrobe,
  output logic [1:0]       ctrlCount,
  output logic [3:0]       sigQualityStepCode,
  output logic             qualityValid
);

  localparam int MW = $clog2(MEAS_CYC + 1);
  localparam int RW = $clog2(READY_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////////
  // start and stop detection, clocked by the data line itself

  logic startTog_ff;
  logic stopTog_ff;

  // scl is steady around a START or STOP edge, so it is read directly
  always_ff @(negedge link.sda or negedge resetn)
    if (!resetn)
      startTog_ff <= 1'b0;
    else if (link.scl)
      startTog_ff <= ~startTog_ff;

  always_ff @(posedge link.sda or negedge resetn)
    if (!resetn)
      stopTog_ff <= 1'b0;
    else if (link.scl)
      stopTog_ff <= ~stopTog_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // link side, bus clock domain

  rdp_link_state_type linkState_ff;
  rdp_link_state_type nxt_linkState;
  logic        startSeen_ff;
  logic [3:0]  bitCnt_ff;
  logic [7:0]  shift_ff;
  logic        ackEn_ff;
  logic [1:0]  wrIdx_ff;
  logic [23:0] wrData_ff;
  logic [2:0]  rdIdx_ff;
  logic [55:0] shadow_ff;
  logic        strapS1_ff, strapS2_ff;
  logic        reqS1_ff, reqS2_ff;
  logic        ackTog_ff, fetchTog_ff, measTog_ff;
  logic        sdaLow_ff;
  logic        reqTog_ff;
  logic [55:0] pubData_ff;

  // START is separated from the next rising scl edge by a full low phase
  wire        newFrame  = startTog_ff ^ startSeen_ff;
  wire        byteEnd   = (bitCnt_ff == 4'h7);
  wire        ackClk    = (bitCnt_ff == 4'h8);
  wire [7:0]  rxByte    = {shift_ff[6:0], link.sda};
  wire        addrMatch = (rxByte[7:1] == {`RDP_ADDR_HI, strapS2_ff});
  wire        wrRoom    = (wrIdx_ff < `RDP_WR_BYTES);
  wire        nxt_ackEn = ((linkState_ff == LNK_ADDR) && addrMatch) ||
                          ((linkState_ff == LNK_WRITE) && wrRoom);
  wire        ownAddrAck = (linkState_ff == LNK_ADDR) && ackClk && ackEn_ff;
  wire        isRead     = shift_ff[0];
  wire [2:0]  nxt_rdIdx  = (linkState_ff == LNK_ADDR) ? 3'h0 :
                           (rdIdx_ff == 3'h7) ? 3'h7 : rdIdx_ff + 3'h1;
  // a read in progress blocks the shadow copy, so one transfer sees one block
  wire        copyNow   = (reqS2_ff != ackTog_ff) &&
                          ((linkState_ff != LNK_READ) || newFrame);
  wire [55:0] rdShifted = shadow_ff << {rdIdx_ff, 3'h0};
  // bit count zero selects the most significant bit of the current byte
  wire        txBit     = rdShifted[6'h37 - {3'h0, bitCnt_ff[2:0]}];
  wire        nxt_sdaLow = ~newFrame &&
                           ((ackClk && ackEn_ff) ||
                            ((linkState_ff == LNK_READ) && ~ackClk && ~txBit));

  always_comb
  begin
    nxt_linkState = linkState_ff;
    unique case (linkState_ff)
      LNK_IDLE:  nxt_linkState = LNK_IDLE;
      LNK_ADDR:  nxt_linkState = ~ackEn_ff ? LNK_IDLE : (isRead ? LNK_READ : LNK_WRITE);
      LNK_WRITE: nxt_linkState = ackEn_ff ? LNK_WRITE : LNK_IDLE;
      LNK_READ:  nxt_linkState = link.sda ? LNK_IDLE : LNK_READ;
    endcase
  end

  always_ff @(posedge link.scl or negedge resetn)
    if (!resetn)
    begin
      strapS1_ff <= 1'b0;
      strapS2_ff <= 1'b0;
      reqS1_ff   <= 1'b0;
      reqS2_ff   <= 1'b0;
    end
    else
    begin
      strapS1_ff <= addrSelectStrap;
      strapS2_ff <= strapS1_ff;
      reqS1_ff   <= reqTog_ff;
      reqS2_ff   <= reqS1_ff;
    end

  always_ff @(posedge link.scl or negedge resetn)
    if (!resetn)
    begin
      shadow_ff <= 56'h00000000000000;
      ackTog_ff <= 1'b0;
    end
    else if (copyNow)
    begin
      shadow_ff <= pubData_ff;
      ackTog_ff <= reqS2_ff;
    end

  always_ff @(posedge link.scl or negedge resetn)
    if (!resetn)
    begin
      startSeen_ff <= 1'b0;
      linkState_ff <= LNK_IDLE;
      bitCnt_ff    <= 4'h0;
      shift_ff     <= 8'h00;
      ackEn_ff     <= 1'b0;
      rdIdx_ff     <= 3'h0;
    end
    else if (newFrame)
    begin
      startSeen_ff <= startTog_ff;
      linkState_ff <= LNK_ADDR;
      bitCnt_ff    <= 4'h1;
      shift_ff     <= {7'h00, link.sda};
      ackEn_ff     <= 1'b0;
    end
    else
    begin
      bitCnt_ff <= ackClk ? 4'h0 : bitCnt_ff + 4'h1;
      shift_ff  <= ackClk ? shift_ff : rxByte;
      ackEn_ff  <= byteEnd ? nxt_ackEn : (ackClk ? 1'b0 : ackEn_ff);
      if (ackClk)
      begin
        linkState_ff <= nxt_linkState;
        rdIdx_ff     <= nxt_rdIdx;
      end
    end

  // write bytes; a byte cut short by STOP is never stored
  always_ff @(posedge link.scl or negedge resetn)
    if (!resetn)
    begin
      wrIdx_ff  <= 2'h0;
      wrData_ff <= 24'h000000;
    end
    else if (newFrame)
      wrIdx_ff <= 2'h0;
    else if (byteEnd && (linkState_ff == LNK_WRITE) && wrRoom)
    begin
      wrData_ff[{wrIdx_ff, 3'h0} +: 8] <= rxByte;
      wrIdx_ff <= wrIdx_ff + 2'h1;
    end

  always_ff @(posedge link.scl or negedge resetn)
    if (!resetn)
    begin
      measTog_ff  <= 1'b0;
      fetchTog_ff <= 1'b0;
    end
    else if (ownAddrAck && !newFrame)
    begin
      measTog_ff  <= ~measTog_ff;
      fetchTog_ff <= fetchTog_ff ^ isRead;
    end

  // data line changes only while scl is low
  always_ff @(negedge link.scl or negedge resetn)
    if (!resetn)
      sdaLow_ff <= 1'b0;
    else
      sdaLow_ff <= nxt_sdaLow;

  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe  = sdaLow_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // core side, crystal clock domain

  logic [3:0]  togS1_ff, togS2_ff, togS3_ff;
  logic        newPend_ff;
  logic [55:0] newBlk_ff;
  logic        blockReadyN_ff;
  logic [RW-1:0] readyCnt_ff;
  logic [23:0] ctrlWord_ff;
  logic        ctrlStrobe_ff;
  logic [1:0]  ctrlCount_ff;
  logic        measBusy_ff;
  logic [MW-1:0] measCnt_ff;
  logic [3:0]  qualCode_ff;
  logic        qualValid_ff;

  wire [3:0] togEdge  = togS2_ff ^ togS3_ff;
  wire       stopEvt  = togEdge[0];
  wire       measEvt  = togEdge[1];
  wire       fetchEvt = togEdge[2];
  wire       publish  = newPend_ff && (reqTog_ff == togS2_ff[3]);
  wire       readyEnd = (readyCnt_ff == RW'(READY_CYC - 1));
  wire       measEnd  = (measCnt_ff == MW'(MEAS_CYC - 1));
  wire [4:0] sens     = ctrlWord_ff[`RDP_SENS_POS +: 5];
  wire [9:0] gainSum  = {2'h0, rfLevel} + {5'h00, sens};
  wire [9:0] adjLevel = gainSum - {5'h00, `RDP_SENS_0DB};
  wire [3:0] nxt_qualCode = (gainSum < {5'h00, `RDP_SENS_0DB}) ? 4'h0 :
                            (adjLevel[9:8] != 2'h0) ? 4'hF : adjLevel[7:4];

  // link registers are quiet after STOP, so they are read once the event lands
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      togS1_ff <= 4'h0;
      togS2_ff <= 4'h0;
      togS3_ff <= 4'h0;
    end
    else
    begin
      togS1_ff <= {ackTog_ff, fetchTog_ff, measTog_ff, stopTog_ff};
      togS2_ff <= togS1_ff;
      togS3_ff <= togS2_ff;
    end

  // a new block arriving as the old one is published is kept
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      newPend_ff <= 1'b0;
      newBlk_ff  <= 56'h00000000000000;
      pubData_ff <= 56'h00000000000000;
      reqTog_ff  <= 1'b0;
    end
    else
    begin
      newPend_ff <= newBlockValid | (newPend_ff & ~publish);
      if (newBlockValid)
        newBlk_ff <= newBlockData;
      if (publish)
      begin
        pubData_ff <= newBlk_ff;
        reqTog_ff  <= ~reqTog_ff;
      end
    end

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      blockReadyN_ff <= 1'b1;
      readyCnt_ff    <= '0;
    end
    else if (publish)
    begin
      blockReadyN_ff <= 1'b0;
      readyCnt_ff    <= '0;
    end
    else if (!blockReadyN_ff)
    begin
      blockReadyN_ff <= fetchEvt | readyEnd;
      readyCnt_ff    <= readyCnt_ff + RW'(1);
    end

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      ctrlWord_ff   <= `RDP_CTRL_RST;
      ctrlCount_ff  <= 2'h0;
      ctrlStrobe_ff <= 1'b0;
    end
    else
    begin
      ctrlStrobe_ff <= stopEvt && (wrIdx_ff != 2'h0);
      if (stopEvt && (wrIdx_ff != 2'h0))
      begin
        ctrlCount_ff <= wrIdx_ff;
        for (int i = 0; i < 3; i++)
          if (wrIdx_ff > 2'(i))
            ctrlWord_ff[8*i +: 8] <= wrData_ff[8*i +: 8];
      end
    end

  // each own-address acknowledge restarts the measurement
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      measBusy_ff  <= 1'b0;
      measCnt_ff   <= '0;
      qualCode_ff  <= 4'h0;
      qualValid_ff <= 1'b0;
    end
    else
    begin
      qualValid_ff <= measBusy_ff && measEnd && !measEvt;
      if (measEvt)
      begin
        measBusy_ff <= 1'b1;
        measCnt_ff  <= '0;
      end
      else if (measBusy_ff)
      begin
        measCnt_ff  <= measCnt_ff + MW'(1);
        measBusy_ff <= ~measEnd;
        if (measEnd)
          qualCode_ff <= nxt_qualCode;
      end
    end

  assign blockReadyN        = blockReadyN_ff;
  assign ctrlWord           = ctrlWord_ff;
  assign ctrlStrobe         = ctrlStrobe_ff;
  assign ctrlCount          = ctrlCount_ff;
  assign sigQualityStepCode = qualCode_ff;
  assign qualityValid       = qualValid_ff;

endmodule : rdp_target_port

/* File: rtl/rdp_bus_master.sv */
// master end: makes the bus clock and runs read and write transfers to the decoder
`timescale 1ns/1ps
`include "rdp_consts.svh"

module rdp_bus_master
  import rdp_pkg::*;
#(
  parameter int QTR_CYC = `RDP_SCL_QTR_CYC
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // two-wire link
  rdp_i2c_if.host          link,
  // command
  input  wire logic        cmdValid,
  input  wire logic        cmdRead,
  input  wire logic        cmdAddrLsb,
  input  wire logic [2:0]  cmdLen,
  input  wire logic [23:0] cmdWrData,
  output logic             cmdReady,
  // response
  output logic             rspDone,
  output logic             rspNack,
  output logic [55:0]      rspData
);

  localparam int QW = $clog2(QTR_CYC + 1);

  rdp_host_state_type state_ff;
  logic [QW-1:0] qCnt_ff;
  logic [1:0]  ph_ff;
  logic [3:0]  bitCnt_ff;
  logic [2:0]  byteCnt_ff, len_ff;
  logic        isAddr_ff, rw_ff, nack_ff;
  logic [7:0]  shift_ff;
  logic [23:0] wrBuf_ff;
  logic [55:0] rdBuf_ff, rspData_ff;
  logic        sclOut_ff, sdaLow_ff, sdaS1_ff, sdaS2_ff, ready_ff, done_ff;

  wire       tick     = (state_ff != HST_IDLE) && (qCnt_ff == QW'(QTR_CYC - 1));
  wire       start    = ready_ff && cmdValid;
  wire       txByte   = isAddr_ff || !rw_ff;
  wire       dataBit  = (bitCnt_ff != 4'h8);
  wire [2:0] nextCnt  = byteCnt_ff + 3'h1;
  // acknowledge all read bytes but the last one
  wire       nxt_sdaLow = dataBit ? (txByte & ~shift_ff[7]) :
                          (~txByte & (nextCnt < len_ff));
  wire       lastByte = isAddr_ff ? (len_ff == 3'h0) : (nextCnt == len_ff);
  wire       endXfer  = nack_ff || lastByte;
  // START spends two quarters, then the bit phases restart at zero
  wire       leaveStart = (state_ff == HST_START) && (ph_ff == 2'h1);

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      qCnt_ff  <= '0;
      ph_ff    <= 2'h0;
      sdaS1_ff <= 1'b1;
      sdaS2_ff <= 1'b1;
    end
    else
    begin
      qCnt_ff  <= (start || tick) ? '0 : qCnt_ff + QW'(1);
      ph_ff    <= start ? 2'h0 : (tick ? (leaveStart ? 2'h0 : ph_ff + 2'h1) : ph_ff);
      sdaS1_ff <= link.sda;
      sdaS2_ff <= sdaS1_ff;
    end

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      state_ff   <= HST_IDLE;
      sclOut_ff  <= 1'b1;
      sdaLow_ff  <= 1'b0;
      ready_ff   <= 1'b1;
      done_ff    <= 1'b0;
      nack_ff    <= 1'b0;
      isAddr_ff  <= 1'b0;
      rw_ff      <= 1'b0;
      len_ff     <= 3'h0;
      bitCnt_ff  <= 4'h0;
      byteCnt_ff <= 3'h0;
      shift_ff   <= 8'h00;
      wrBuf_ff   <= 24'h000000;
      rdBuf_ff   <= 56'h00000000000000;
      rspData_ff <= 56'h00000000000000;
    end
    else
    begin
      done_ff <= 1'b0;
      if (start)
      begin
        state_ff   <= HST_START;
        ready_ff   <= 1'b0;
        nack_ff    <= 1'b0;
        isAddr_ff  <= 1'b1;
        rw_ff      <= cmdRead;
        len_ff     <= cmdLen;
        bitCnt_ff  <= 4'h0;
        byteCnt_ff <= 3'h0;
        shift_ff   <= {`RDP_ADDR_HI, cmdAddrLsb, cmdRead};
        wrBuf_ff   <= cmdWrData;
      end
      else if (tick)
        unique case (state_ff)
          HST_START:
            if (ph_ff == 2'h0)
              sdaLow_ff <= 1'b1;
            else
            begin
              sclOut_ff <= 1'b0;
              state_ff  <= HST_BIT;
            end
          HST_BIT:
            unique case (ph_ff)
              2'h0: sdaLow_ff <= nxt_sdaLow;
              2'h1: sclOut_ff <= 1'b1;
              2'h2:
                if (dataBit)
                  shift_ff <= {shift_ff[6:0], sdaS2_ff};
                else if (txByte && sdaS2_ff)
                  nack_ff <= 1'b1;
              2'h3:
              begin
                sclOut_ff <= 1'b0;
                bitCnt_ff <= dataBit ? bitCnt_ff + 4'h1 : 4'h0;
                if (!dataBit)
                begin
                  isAddr_ff  <= 1'b0;
                  byteCnt_ff <= isAddr_ff ? 3'h0 : nextCnt;
                  if (!txByte)
                    rdBuf_ff <= {rdBuf_ff[47:0], shift_ff};
                  if (txByte)
                  begin
                    shift_ff <= wrBuf_ff[7:0];
                    wrBuf_ff <= {8'h00, wrBuf_ff[23:8]};
                  end
                  state_ff <= endXfer ? HST_STOP : HST_BIT;
                end
              end
            endcase
          HST_STOP:
            unique case (ph_ff)
              2'h0: sdaLow_ff <= 1'b1;
              2'h1: sclOut_ff <= 1'b1;
              2'h2: sdaLow_ff <= 1'b0;
              2'h3:
              begin
                state_ff   <= HST_IDLE;
                ready_ff   <= 1'b1;
                done_ff    <= 1'b1;
                rspData_ff <= rdBuf_ff << {3'h7 - len_ff, 3'h0};
              end
            endcase
          HST_IDLE: state_ff <= HST_IDLE;
        endcase
    end

  assign link.scl        = sclOut_ff;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = sdaLow_ff;
  assign cmdReady        = ready_ff;
  assign rspDone         = done_ff;
  assign rspNack         = nack_ff;
  assign rspData         = rspData_ff;

endmodule : rdp_bus_master

/* File: verification/rdp_link_chk.sv */
// link checker: framing, acknowledge and release rules seen on the wires
`timescale 1ns/1ps
module rdp_link_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // link wires
  input wire logic scl,
  input wire logic hostSdaOe,
  input wire logic devSdaOe,
  input wire logic sda,
  // address select level of the target
  input wire logic addrStrap
);
  logic       sclQ_ff;
  logic       sdaQ_ff;
  logic       readMode_ff;
  logic [3:0] bitCnt_ff;
  logic [2:0] byteNum_ff;
  logic [7:0] shift_ff;
  wire        startSeen = scl & sclQ_ff & sdaQ_ff & ~sda;
  wire        sclRise   = scl & ~sclQ_ff;
  wire        ackSlot   = sclRise & (bitCnt_ff == 4'h8);
  wire        foreign   = (byteNum_ff == 3'h0) & (shift_ff[7:1] != {6'h08, addrStrap});
  ////////////////////////////////////////////////////////////////////////////
  // byte and bit position within the frame, restarted at every start
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclQ_ff     <= 1'b1;
      sdaQ_ff     <= 1'b1;
      readMode_ff <= 1'b0;
      bitCnt_ff   <= 4'h0;
      byteNum_ff  <= 3'h0;
      shift_ff    <= 8'h00;
    end
    else
    begin
      sclQ_ff <= scl;
      sdaQ_ff <= sda;
      if (startSeen)
      begin
        bitCnt_ff  <= 4'h0;
        byteNum_ff <= 3'h0;
      end
      else if (ackSlot)
      begin
        bitCnt_ff   <= 4'h0;
        byteNum_ff  <= byteNum_ff + {2'h0, byteNum_ff != 3'h7};
        readMode_ff <= (byteNum_ff == 3'h0) ? shift_ff[0] : readMode_ff;
      end
      else if (sclRise)
      begin
        bitCnt_ff <= bitCnt_ff + 4'h1;
        shift_ff  <= {shift_ff[6:0], sda};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  dev_data_stable_a: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("target moved data while clock high");
  foreign_no_ack_a: assert property (ackSlot && foreign |-> sda)
    else $error("foreign address acknowledged");
  foreign_stays_off_a: assert property (ackSlot && foreign |=> !devSdaOe [*8])
    else $error("target drove after foreign address");
  read_ack_free_a: assert property (ackSlot && readMode_ff && byteNum_ff != 3'h0 |-> !devSdaOe)
    else $error("target drove during master acknowledge");
  host_ack_off_a: assert property (ackSlot && (byteNum_ff == 3'h0 || !readMode_ff) |-> !hostSdaOe)
    else $error("master drove during target acknowledge");
  excess_byte_nack_a: assert property (ackSlot && !readMode_ff && byteNum_ff >= 3'h4 |-> sda)
    else $error("fourth write byte acknowledged");
  stop_release_a: assert property (scl && $past(scl) && $rose(sda) |=> !devSdaOe [*3])
    else $error("target drove after stop");
  scl_low_bound_a: assert property ($fell(scl) |-> ##[1:12] scl)
    else $error("bus clock held low too long");

  cover property (ackSlot && readMode_ff && byteNum_ff == 3'h7);
  cover property (ackSlot && foreign);
  cover property (ackSlot && !readMode_ff && byteNum_ff == 3'h4);
endmodule : rdp_link_chk

/* File: verification/rds_decoder_i2c_target_port_test.sv */
// self-checking bench: master and target port joined over the link
`timescale 1ns/1ps
module rds_decoder_i2c_target_port_test;
  import rdp_pkg::*;
  localparam int QTR = 4;
  localparam int MEAS = 40;
  localparam int READY = 2000;
  logic        mclk, resetn, strap, blkValid, blockReadyN, ctrlStrobe, qValid;
  logic        cmdValid, cmdRead, cmdLsb, cmdReady, rspDone, rspNack;
  logic [55:0] blkData, rspData, blk, blk2;
  logic [23:0] cmdWrData, ctrlWord, wr;
  logic [7:0]  rfLevel;
  logic [4:0]  sens;
  logic [3:0]  qCode;
  logic [2:0]  cmdLen;
  logic [1:0]  ctrlCount;
  int          n_mismatch, num_checks, seed, nStrobe, k, i;

  rdp_i2c_if link();
  rdp_target_port #(.MEAS_CYC(MEAS), .READY_CYC(READY)) rdp_target_port_i (
    .mclk(mclk), .resetn(resetn), .link(link), .addrSelectStrap(strap),
    .newBlockValid(blkValid), .newBlockData(blkData), .rfLevel(rfLevel),
    .blockReadyN(blockReadyN), .ctrlWord(ctrlWord), .ctrlStrobe(ctrlStrobe),
    .ctrlCount(ctrlCount), .sigQualityStepCode(qCode), .qualityValid(qValid));
  rdp_bus_master #(.QTR_CYC(QTR)) rdp_bus_master_i (
    .mclk(mclk), .resetn(resetn), .link(link), .cmdValid(cmdValid),
    .cmdRead(cmdRead), .cmdAddrLsb(cmdLsb), .cmdLen(cmdLen), .cmdWrData(cmdWrData),
    .cmdReady(cmdReady), .rspDone(rspDone), .rspNack(rspNack), .rspData(rspData));
  rdp_link_chk rdp_link_chk_i (.mclk(mclk), .resetn(resetn), .scl(link.scl),
    .hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe), .sda(link.sda),
    .addrStrap(strap));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) if (ctrlStrobe === 1'b1) nStrobe++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // one whole transfer; a few idle cycles after so the target commits
  task automatic xfer(input logic rd, input logic lsb, input logic [2:0] len,
                      input logic [23:0] d);
    int t;
    @(negedge mclk);
    cmdValid  = 1'b1;
    cmdRead   = rd;
    cmdLsb    = lsb;
    cmdLen    = len;
    cmdWrData = d;
    @(negedge mclk);
    cmdValid = 1'b0;
    t = 0;
    while (rspDone !== 1'b1 && t < 3000)
    begin
      @(negedge mclk);
      t++;
    end
    check(t < 3000, 1, "transfer end");
    check(cmdReady, 1, "master not idle");
    repeat (8) @(negedge mclk);
  endtask : xfer

  task automatic wrFull(input logic [23:0] d);
    xfer(1'b0, strap, 3'h3, d);
    check(rspNack, 0, "write refused");
    check(ctrlWord, d, "control word");
    check(ctrlCount, 3, "byte count");
  endtask : wrFull

  task automatic newBlock(input logic [55:0] d);
    @(negedge mclk);
    blkData  = d;
    blkValid = 1'b1;
    @(negedge mclk);
    blkValid = 1'b0;
  endtask : newBlock

  function automatic logic [3:0] qcode(input logic [7:0] rf, input logic [4:0] s);
    int v;
    v = (int'(rf) + int'(s) - 15) >>> 4;
    return (v < 0) ? 4'h0 : (v > 15) ? 4'hF : v[3:0];
  endfunction : qcode
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    seed = 32'hDBC6;
    {resetn, strap, blkValid, cmdValid, cmdRead, cmdLsb} = 6'h00;
    {blkData, cmdWrData, rfLevel, cmdLen} = '0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    check(ctrlWord, 24'h0F0000, "control reset");
    check(blockReadyN, 1, "ready reset");
    // foreign then own address at both strap levels
    wr = 24'h0F0000;
    for (i = 0; i < 2; i++)
    begin
      strap = i[0];
      xfer(1'b0, ~strap, 3'h3, $random(seed));
      check(rspNack, 1, "foreign acknowledged");
      check(ctrlWord, wr, "foreign wrote");
      wr = (i == 0) ? 24'h2F5A5A : 24'h2A4A4A;
      wrFull(wr);
    end
    check(nStrobe, 2, "strobe count");
    xfer(1'b0, strap, 3'h4, $random(seed));
    check(rspNack, 1, "fourth byte taken");
    wr = $random(seed);
    wrFull(wr);
    xfer(1'b0, strap, 3'h1, 24'h0000C3);
    check(ctrlWord, {wr[23:8], 8'hC3}, "short write word");
    check(ctrlCount, 1, "short write count");
    // quality code over gain settings, clamp at both ends
    for (i = 0; i < 4; i++)
    begin
      sens = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : (i == 2) ? 5'h0F : $random(seed);
      wrFull({3'h0, sens, 16'h1234});
      rfLevel = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $random(seed);
      fork
        xfer(1'b1, strap, 3'h1, 24'h0);
        begin
          k = 0;
          while (qValid !== 1'b1 && k < 400)
          begin
            @(negedge mclk);
            k++;
          end
          check(k <= 152 + MEAS + 16, 1, "measure time");
          check(qCode, qcode(rfLevel, sens), "quality code");
        end
      join
    end
    // block ready timing, read order and block stability
    blk = {$random(seed), $random(seed)};
    fork
      begin
        newBlock(blk);
        xfer(1'b0, strap, 3'h0, 24'h0);
      end
      begin
        k = 0;
        while (blockReadyN !== 1'b0 && k < 600)
        begin
          @(negedge mclk);
          k++;
        end
        k = 0;
        while (blockReadyN === 1'b0 && k < 3000)
        begin
          @(negedge mclk);
          k++;
        end
        check(k >= READY - 4 && k <= READY + 4, 1, "ready low time");
      end
    join
    blk2 = {$random(seed), $random(seed)};
    fork
      xfer(1'b1, strap, 3'h7, 24'h0);
      begin
        repeat (700) @(negedge mclk);
        newBlock(blk2);
      end
    join
    check(rspData, blk, "read block");
    xfer(1'b0, strap, 3'h0, 24'h0);
    check(blockReadyN, 0, "ready not low");
    xfer(1'b1, strap, 3'h3, 24'h0);
    check(blockReadyN, 1, "ready not released");
    check(rspData, {blk2[55:32], 32'h0}, "short read");
    complete_run();
  end
endmodule : rds_decoder_i2c_target_port_test
